// File: rtl/lgp_pkg.sv
/*
  package of the gray, power and reset control block: apb register map,
  field positions, reset values and limits.
  assumes a 32-bit apb with word-aligned registers.
*/
package lgp_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CMD     = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_DISP    = 8'h08;
  localparam logic [7:0] OFF_ADDR    = 8'h0c;
  localparam logic [7:0] OFF_LINES   = 8'h10;
  localparam logic [7:0] OFF_POWER   = 8'h14;
  localparam logic [7:0] OFF_GRAYCFG = 8'h18;
  localparam logic [7:0] OFF_PALETTE = 8'h40;
  localparam logic [7:0] OFF_PAL_END = 8'h7c;
  // ----------------------------------------------------------------
  // command and status register fields
  // ----------------------------------------------------------------
  localparam int CMD_RESET_BIT   = 0;
  localparam int STATUS_RES_BIT  = 4;
  // ----------------------------------------------------------------
  // partial display limits
  // ----------------------------------------------------------------
  localparam logic [7:0] PART_MIN    = 8'h10;
  localparam logic [7:0] PART_MAX_M0 = 8'h80;
  localparam logic [7:0] PART_MAX_M1 = 8'h64;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PARTIAL  = 8'h80;
  localparam logic [5:0] RST_CONTRAST = 6'h20;
  localparam logic [2:0] RST_BIAS     = 3'h0;
  localparam logic [2:0] RST_POWER    = 3'h0;
  localparam logic [1:0] RST_STEPUP   = 2'h0;
  localparam logic       RST_BOOST_EF = 1'b1;
  localparam logic [2:0] RST_RATIO    = 3'h0;
  localparam logic [5:0] PAL_EVEN     = 6'h00;
  localparam logic [5:0] PAL_ODD      = 6'h3f;
  // ----------------------------------------------------------------
  // gray steps; codes beyond the top step give the off level
  // ----------------------------------------------------------------
  localparam logic [5:0] STEPS_45 = 6'h2d;
  localparam logic [5:0] STEPS_60 = 6'h3c;
  // regulator gain in tenths: 23 + 7*code
  localparam logic [6:0] GAIN_BASE = 7'h17;
  localparam logic [6:0] GAIN_STEP = 7'h07;
  // internal init duration in pclk cycles
  localparam logic [3:0] INIT_CYCLES = 4'h8;
endpackage

// File: rtl/lgp_ctrl.sv
/*
  gray palette, partial display, power and reset control as an apb slave.
  assumes apb3 master on pclk; the hardware reset pin is asynchronous to pclk.
*/
// Our own choices: the address map and register access over APB.
`timescale 1ns/100ps
module lgp_ctrl
(
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // hardware reset pin, asynchronous
  input  wire logic        hw_reset_low,
  // power circuit enables, regulator gain and contrast
  output logic             booster_enable,
  output logic             regulator_enable,
  output logic             follower_enable,
  output logic      [6:0]  regulator_gain,
  output logic      [5:0]  contrast_level,
  // gray level lookup
  input  wire logic [3:0]  gray_sel,
  output logic      [5:0]  pwm_on_width,
  output logic      [5:0]  pwm_period
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {LGP_IDLE = 2'b00, LGP_INIT = 2'b01} lgp_state_e;
  lgp_state_e  state;
  logic [3:0]  init_cnt;
  logic [2:0]  rst_sync;
  logic        hw_rst;
  logic        cmd_reset;
  logic        busy;
  logic [3:0]  page_addr;
  logic [9:0]  col_addr;
  logic        modify_read;
  logic        display_on;
  logic [6:0]  init_line;
  logic [6:0]  first_common_line;
  logic        reverse;
  logic [4:0]  nline_inv;
  logic        entire_on;
  logic        symbol_row_enable;
  logic [7:0]  partial_ratio;
  logic        disp_mode;
  logic [2:0]  power_ctrl;
  logic [1:0]  stepup_sel;
  logic        booster_efficiency;
  logic [2:0]  regulator_ratio_sel;
  logic [5:0]  elec_volume;
  logic [2:0]  bias_sel;
  logic        com_dir;
  logic        seg_dir;
  logic        osc_on;
  logic        power_save;
  logic [7:0]  data_length;
  logic        frame_modulation_count;
  logic [1:0]  pwm_mode;
  logic [5:0]  palette_level [16];
  logic        wr_en;
  logic        addr_ok;
  logic        pal_hit;
  logic [3:0]  pal_idx;
  logic [7:0]  max_part;
  logic [5:0]  steps;
  logic [5:0]  code;

  // apb: zero wait states, bad address or locked access gives pslverr
  assign pal_hit = (paddr >= lgp_pkg::OFF_PALETTE) && (paddr <= lgp_pkg::OFF_PAL_END);
  assign pal_idx = paddr[5:2];
  assign addr_ok = pal_hit || (paddr == lgp_pkg::OFF_CMD) || (paddr == lgp_pkg::OFF_STATUS)
                   || (paddr == lgp_pkg::OFF_DISP) || (paddr == lgp_pkg::OFF_ADDR)
                   || (paddr == lgp_pkg::OFF_LINES) || (paddr == lgp_pkg::OFF_POWER)
                   || (paddr == lgp_pkg::OFF_GRAYCFG);
  assign pready  = 1'b1;
  // only status reads pass while busy
  assign pslverr = psel && penable && (!addr_ok || (busy &&
                   !(!pwrite && paddr == lgp_pkg::OFF_STATUS)));
  assign wr_en   = psel && penable && pwrite && addr_ok && !busy;
  assign cmd_reset = wr_en && (paddr == lgp_pkg::OFF_CMD) && pwdata[lgp_pkg::CMD_RESET_BIT];

  // ----------------------------------------------------------------
  // hardware reset pin synchroniser
  // ----------------------------------------------------------------
  // three flops; asserted once the last two agree low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rst_sync <= 3'h0;
    else
      rst_sync <= {rst_sync[1:0], hw_reset_low};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hw_rst <= 1'b1;
    else if (rst_sync[1] == rst_sync[2])
      hw_rst <= !rst_sync[2];
  end

  // ----------------------------------------------------------------
  // reset sequencer
  // ----------------------------------------------------------------
  // init runs a fixed time after either reset source
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state    <= LGP_INIT;
      init_cnt <= lgp_pkg::INIT_CYCLES;
    end
    else if (hw_rst || cmd_reset)
    begin
      state    <= LGP_INIT;
      init_cnt <= lgp_pkg::INIT_CYCLES;
    end
    else
    begin
      unique case (state)
        LGP_IDLE: state <= LGP_IDLE;
        LGP_INIT:
        begin
          init_cnt <= init_cnt - 4'h1;
          if (init_cnt == 4'h1)
            state <= LGP_IDLE;
        end
        default: state <= LGP_IDLE;
      endcase
    end
  end

  // busy covers pin low and init countdown
  assign busy = hw_rst || (state == LGP_INIT);

  // ----------------------------------------------------------------
  // fields restored to reset values by both resets
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      page_addr           <= 4'h0;
      col_addr            <= 10'h000;
      modify_read         <= 1'b0;
      init_line           <= 7'h00;
      regulator_ratio_sel <= lgp_pkg::RST_RATIO;
      elec_volume         <= lgp_pkg::RST_CONTRAST;
      data_length         <= 8'h00;
      frame_modulation_count <= 1'b0;
      pwm_mode            <= 2'h0;
    end
    else if (hw_rst || cmd_reset)
    begin
      page_addr           <= 4'h0;
      col_addr            <= 10'h000;
      modify_read         <= 1'b0;
      init_line           <= 7'h00;
      regulator_ratio_sel <= lgp_pkg::RST_RATIO;
      elec_volume         <= lgp_pkg::RST_CONTRAST;
      data_length         <= 8'h00;
      frame_modulation_count <= 1'b0;
      pwm_mode            <= 2'h0;
    end
    else if (wr_en)
    begin
      if (paddr == lgp_pkg::OFF_ADDR)
      begin
        page_addr   <= pwdata[3:0];
        col_addr    <= pwdata[13:4];
        modify_read <= pwdata[16];
      end
      if (paddr == lgp_pkg::OFF_LINES)
        init_line <= pwdata[6:0];
      if (paddr == lgp_pkg::OFF_POWER)
      begin
        regulator_ratio_sel <= pwdata[6:4];
        elec_volume         <= pwdata[13:8];
      end
      if (paddr == lgp_pkg::OFF_GRAYCFG)
      begin
        frame_modulation_count <= pwdata[0];
        pwm_mode               <= pwdata[2:1];
        data_length            <= pwdata[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // fields set only by the hardware reset
  // ----------------------------------------------------------------
  // command reset leaves these alone
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      display_on <= 1'b0; first_common_line <= 7'h00; reverse <= 1'b0;
      nline_inv <= 5'h00; entire_on <= 1'b0; symbol_row_enable <= 1'b0;
      partial_ratio <= lgp_pkg::RST_PARTIAL; disp_mode <= 1'b0;
      power_ctrl <= lgp_pkg::RST_POWER; stepup_sel <= lgp_pkg::RST_STEPUP;
      booster_efficiency <= lgp_pkg::RST_BOOST_EF; bias_sel <= lgp_pkg::RST_BIAS;
      com_dir <= 1'b0; seg_dir <= 1'b0; osc_on <= 1'b0; power_save <= 1'b0;
    end
    else if (hw_rst)
    begin
      display_on        <= 1'b0;
      first_common_line <= 7'h00;
      reverse           <= 1'b0;
      nline_inv         <= 5'h00;
      entire_on         <= 1'b0;
      symbol_row_enable <= 1'b0;
      partial_ratio     <= lgp_pkg::RST_PARTIAL;
      disp_mode         <= 1'b0;
      power_ctrl        <= lgp_pkg::RST_POWER;
      stepup_sel        <= lgp_pkg::RST_STEPUP;
      booster_efficiency <= lgp_pkg::RST_BOOST_EF;
      bias_sel          <= lgp_pkg::RST_BIAS;
      com_dir           <= 1'b0;
      seg_dir           <= 1'b0;
      osc_on            <= 1'b0;
      power_save        <= 1'b0;
    end
    else if (wr_en && !cmd_reset)
    begin
      if (paddr == lgp_pkg::OFF_DISP)
      begin
        display_on        <= pwdata[0];
        reverse           <= pwdata[1];
        entire_on         <= pwdata[2];
        symbol_row_enable <= pwdata[3];
        com_dir           <= pwdata[4];
        seg_dir           <= pwdata[5];
        osc_on            <= pwdata[6];
        power_save        <= pwdata[7];
        disp_mode         <= pwdata[8];
        nline_inv         <= pwdata[20:16];
      end
      if (paddr == lgp_pkg::OFF_LINES)
      begin
        first_common_line <= pwdata[14:8];
        // out-of-range ratio is dropped, old value kept
        if (pwdata[23:16] >= lgp_pkg::PART_MIN && pwdata[23:16] <= max_part)
          partial_ratio <= pwdata[23:16];
      end
      if (paddr == lgp_pkg::OFF_POWER)
      begin
        power_ctrl         <= pwdata[2:0];
        stepup_sel         <= pwdata[17:16];
        booster_efficiency <= pwdata[18];
        bias_sel           <= pwdata[22:20];
      end
    end
  end

  // mode selects the upper ratio limit
  assign max_part = disp_mode ? lgp_pkg::PART_MAX_M1 : lgp_pkg::PART_MAX_M0;

  // ----------------------------------------------------------------
  // palette
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 16; i++)
        palette_level[i] <= i[0] ? lgp_pkg::PAL_ODD : lgp_pkg::PAL_EVEN;
    end
    else if (hw_rst || cmd_reset)
    begin
      for (int i = 0; i < 16; i++)
        palette_level[i] <= i[0] ? lgp_pkg::PAL_ODD : lgp_pkg::PAL_EVEN;
    end
    else if (wr_en && pal_hit)
      palette_level[pal_idx] <= pwdata[5:0];
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign booster_enable   = power_ctrl[2];
  assign regulator_enable = power_ctrl[1];
  assign follower_enable  = power_ctrl[0];
  assign contrast_level   = elec_volume;

  // gain in tenths; code is only 3 bits so the sum stays under 7 bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      regulator_gain <= lgp_pkg::GAIN_BASE;
    else
      regulator_gain <= 7'(lgp_pkg::GAIN_BASE + lgp_pkg::GAIN_STEP * {4'h0, regulator_ratio_sel});
  end

  // pwm_mode bit 1 picks 60 steps
  assign steps = pwm_mode[1] ? lgp_pkg::STEPS_60 : lgp_pkg::STEPS_45;
  assign code  = palette_level[gray_sel];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwm_on_width <= 6'h00;
      pwm_period   <= lgp_pkg::STEPS_45;
    end
    else
    begin
      pwm_period   <= steps;
      // codes above the top step fall to the off level
      pwm_on_width <= (code <= steps) ? code : 6'h00;
    end
  end

  // read mux; status shows reset progress
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      prdata <= 32'h0000_0000;
      if (paddr == lgp_pkg::OFF_STATUS)
        prdata <= {27'h0, busy, 1'b0, display_on, 2'h0};
      else if (busy)
        prdata <= 32'h0000_0000;
      else if (pal_hit)
        prdata <= {26'h0, palette_level[pal_idx]};
      else if (paddr == lgp_pkg::OFF_DISP)
        prdata <= {11'h0, nline_inv, 7'h0, disp_mode, power_save, osc_on, seg_dir, com_dir,
                   symbol_row_enable, entire_on, reverse, display_on};
      else if (paddr == lgp_pkg::OFF_ADDR)
        prdata <= {15'h0, modify_read, 2'h0, col_addr, page_addr};
      else if (paddr == lgp_pkg::OFF_LINES)
        prdata <= {8'h0, partial_ratio, 1'b0, first_common_line, 1'b0, init_line};
      else if (paddr == lgp_pkg::OFF_POWER)
        prdata <= {9'h0, bias_sel, 1'b0, booster_efficiency, stepup_sel, 2'h0,
                   elec_volume, 1'b0, regulator_ratio_sel, 1'b0, power_ctrl};
      else if (paddr == lgp_pkg::OFF_GRAYCFG)
        prdata <= {16'h0, data_length, 5'h0, pwm_mode, frame_modulation_count};
    end
  end
endmodule

// File: sim/lgp_ctrl_assertions.sv
/*
  checker of lgp_ctrl: power bits, gain, volume, gray widths, refusals.
  assumes it is bound onto lgp_ctrl and sees only its ports.
*/
`timescale 1ns/100ps
module lgp_ctrl_chk
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        pslverr,
  // pin and outputs
  input  wire logic        hw_reset_low,
  input  wire logic        booster_enable,
  input  wire logic        regulator_enable,
  input  wire logic        follower_enable,
  input  wire logic [6:0]  regulator_gain,
  input  wire logic [5:0]  contrast_level,
  input  wire logic [5:0]  pwm_on_width,
  input  wire logic [5:0]  pwm_period
);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_wr_power;
    psel && penable && pwrite && paddr == lgp_pkg::OFF_POWER && !pslverr;
  endsequence
  sequence s_cmd_reset;
    psel && penable && pwrite && paddr == lgp_pkg::OFF_CMD && pwdata[0] && !pslverr;
  endsequence
  sequence s_other;
    psel && penable && paddr != lgp_pkg::OFF_STATUS;
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_power_bits;
    s_wr_power |=> {booster_enable, regulator_enable, follower_enable} == $past(pwdata[2:0]);
  endproperty
  property p_volume;
    s_wr_power |=> contrast_level == $past(pwdata[13:8]);
  endproperty
  // gain lags the stored ratio by one register stage
  property p_gain;
    s_wr_power |-> ##2
      regulator_gain == lgp_pkg::GAIN_BASE + lgp_pkg::GAIN_STEP * $past(pwdata[6:4], 2);
  endproperty
  // first edge after release still shows reset contents, so it is skipped
  property p_period;
    $past(presetn) |-> pwm_period == lgp_pkg::STEPS_45 || pwm_period == lgp_pkg::STEPS_60;
  endproperty
  property p_width;
    $past(presetn) |-> pwm_on_width <= pwm_period;
  endproperty
  property p_pin_busy;
    (!hw_reset_low) [*6] ##0 s_other |-> pslverr;
  endproperty
  property p_cmd_busy;
    s_cmd_reset ##[1:4] s_other |-> pslverr;
  endproperty
  property p_rst_power;
    $rose(presetn) |-> !booster_enable && !regulator_enable && !follower_enable;
  endproperty
  property p_rst_volume;
    $rose(presetn) |-> contrast_level == lgp_pkg::RST_CONTRAST;
  endproperty
  property p_unmapped;
    s_acc ##0 (paddr inside {[8'h1c:8'h3c]} || paddr > lgp_pkg::OFF_PAL_END) |-> pslverr;
  endproperty
  a_power_bits: assert property (p_power_bits)
    else $error("power enables differ from written bits");
  a_volume: assert property (p_volume)
    else $error("volume differs from written value");
  a_gain: assert property (p_gain)
    else $error("regulator gain wrong for ratio code");
  a_period: assert property (p_period)
    else $error("pwm period is neither step count");
  a_width: assert property (p_width)
    else $error("on width above period");
  a_pin_busy: assert property (p_pin_busy)
    else $error("access accepted while pin reset low");
  a_cmd_busy: assert property (p_cmd_busy)
    else $error("access accepted during command reset");
  a_rst_power: assert property (p_rst_power)
    else $error("power enables not off after reset");
  a_rst_volume: assert property (p_rst_volume)
    else $error("volume not at reset level");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
endmodule
bind lgp_ctrl lgp_ctrl_chk u_chk
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .hw_reset_low(hw_reset_low),
  .booster_enable(booster_enable), .regulator_enable(regulator_enable),
  .follower_enable(follower_enable), .regulator_gain(regulator_gain),
  .contrast_level(contrast_level), .pwm_on_width(pwm_on_width), .pwm_period(pwm_period)
);

// File: sim/lgp_host.sv
/*
  host model: apb master transfers, status polling and the reset pin.
  assumes an apb slave on pclk that may insert wait states.
*/
`timescale 1ns/100ps
module lgp_host
(
  // clock
  input  wire logic        pclk,
  // apb master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // reset pin
  output logic             hw_reset_low
);
  // pin starts low so block and host come up together
  initial
  begin
    {psel, penable, pwrite} = 3'h0;
    paddr        = 8'h00;
    pwdata       = 32'h0;
    hw_reset_low = 1'b0;
  end
  // one transfer; request held until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // answer taken at the rising edge that shows pready high
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    q = prdata;
    e = pslverr;
    // a lost answer poisons the result so every caller but wait_idle flags it; wait_idle polls again
    if (pready !== 1'b1)
    begin
      q = 'x;
      e = 1'bx;
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pin(input logic v);
    @(posedge pclk);
    hw_reset_low <= v;
  endtask
  // only status reads until the reset bit clears
  task automatic wait_idle(output logic ok);
    logic [31:0] q;
    logic        e;
    int          n;
    ok = 1'b0;
    for (n = 0; n < 40 && !ok; n++)
    begin
      xfer(1'b0, lgp_pkg::OFF_STATUS, 32'h0, q, e);
      ok = (q[lgp_pkg::STATUS_RES_BIT] === 1'b0);
    end
  endtask
endmodule

// File: sim/lcd_gray_power_reset_ctrl_tb_top.sv
/*
  testbench of lgp_ctrl: reset values, power and gain, gray widths,
  partial limits, command reset and pin reset.
  assumes lgp_host as apb master and reset pin driver.
*/
`timescale 1ns/100ps
module lcd_gray_power_reset_ctrl_tb_top;
  // ----------------------------------------------------------------
  // signals and tables
  // ----------------------------------------------------------------
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, hw_reset_low, e, ok;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, d;
  logic        booster_enable, regulator_enable, follower_enable;
  logic [6:0]  regulator_gain;
  logic [5:0]  contrast_level, pwm_on_width, pwm_period;
  logic [3:0]  gray_sel = 4'h0;
  logic [2:0]  p;
  int          miscompares = 0;
  int          check_count = 0;
  int          i, k, v, top, ex;
  int          pw [4] = '{7, 3, 1, 0};
  int          gc [9] = '{0, 1, 44, 45, 46, 59, 60, 61, 63};
  int          pm [8] = '{0, 0, 0, 0, 1, 1, 1, 1};
  int          pr [8] = '{15, 16, 128, 129, 128, 100, 101, 16};
  // free-running clock
  always #25 pclk = ~pclk;
  lgp_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hw_reset_low(hw_reset_low));
  lgp_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hw_reset_low(hw_reset_low), .booster_enable(booster_enable),
    .regulator_enable(regulator_enable), .follower_enable(follower_enable),
    .regulator_gain(regulator_gain), .contrast_level(contrast_level),
    .gray_sel(gray_sel), .pwm_on_width(pwm_on_width), .pwm_period(pwm_period));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x)
    begin
      $display("BAD %s expected %h seen %h", nm, x, g);
      miscompares++;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] rq;
    logic        re;
    host.xfer(1'b0, a, 32'h0, rq, re);
    chk($sformatf("reg %h", a), x, rq);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] rq;
    logic        re;
    host.xfer(1'b1, a, wd, rq, re);
    chk($sformatf("write err %h", a), 32'h0, {31'h0, re});
  endtask
  // access that must be refused
  task automatic xerr(input logic w, input logic [7:0] a);
    logic [31:0] rq;
    logic        re;
    host.xfer(w, a, 32'h7, rq, re);
    chk($sformatf("refused %h", a), 32'h1, {31'h0, re});
  endtask
  task automatic idle();
    host.wait_idle(ok);
    chk("idle", 32'h1, {31'h0, ok});
  endtask
  task automatic settle();
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic hw_defaults();
    rd(lgp_pkg::OFF_POWER, 32'h0004_2000);
    rd(lgp_pkg::OFF_LINES, 32'h0080_0000);
    rd(lgp_pkg::OFF_DISP, 32'h0);
    rd(lgp_pkg::OFF_ADDR, 32'h0);
    chk("enables", 32'h0, {booster_enable, regulator_enable, follower_enable});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    host.pin(1'b1);
    idle();
    hw_defaults();
    rd(lgp_pkg::OFF_GRAYCFG, 32'h0);
    rd(lgp_pkg::OFF_CMD, 32'h0);
    for (i = 0; i < 16; i++)
      rd(lgp_pkg::OFF_PALETTE + 8'(4 * i), i[0] ? 32'h3f : 32'h0);
    xerr(1'b0, 8'h20);
    $display("test reset values done");
    // power combinations, ratio codes and volume boundary
    for (i = 0; i < 8; i++)
    begin
      p = 3'(pw[i % 4]);
      v = (i == 7) ? 63 : i * 9;
      d = 32'h0004_0000 | 32'(v << 8) | 32'(i << 4) | 32'(p);
      wr(lgp_pkg::OFF_POWER, d);
      settle();
      chk("enables", 32'(p), {booster_enable, regulator_enable, follower_enable});
      chk("gain", 32'(23 + 7 * i), regulator_gain);
      chk("volume", 32'(v), contrast_level);
    end
    $display("test power done");
    // gray widths in both step modes, codes at and past the top
    for (i = 0; i < 2; i++)
    begin
      wr(lgp_pkg::OFF_GRAYCFG, i ? 32'h4 : 32'h0);
      top = i ? 60 : 45;
      for (k = 0; k < 9; k++)
      begin
        wr(lgp_pkg::OFF_PALETTE + 8'(4 * k), 32'(gc[k]));
        gray_sel <= 4'(k);  // wr returns on a rising edge
        settle();
        chk("width", (gc[k] <= top) ? 32'(gc[k]) : 32'h0, pwm_on_width);
        chk("period", 32'(top), pwm_period);
      end
    end
    $display("test gray done");
    // partial ratio limits per display mode
    ex = 128;
    for (i = 0; i < 8; i++)
    begin
      wr(lgp_pkg::OFF_DISP, 32'(pm[i] << 8));
      wr(lgp_pkg::OFF_LINES, 32'(pr[i] << 16) | 32'h0503);
      if (pr[i] >= 16 && pr[i] <= (pm[i] ? 100 : 128))
        ex = pr[i];
      rd(lgp_pkg::OFF_LINES, 32'(ex << 16) | 32'h0503);
    end
    $display("test partial done");
    // command reset touches only its own list
    wr(lgp_pkg::OFF_DISP, 32'h0000_00ff);
    wr(lgp_pkg::OFF_ADDR, 32'h0001_0125);
    wr(lgp_pkg::OFF_LINES, 32'h0040_0705);
    wr(lgp_pkg::OFF_POWER, 32'h0032_0a57);
    wr(lgp_pkg::OFF_GRAYCFG, 32'h0000_0107);
    wr(lgp_pkg::OFF_PALETTE + 8'h08, 32'h15);
    wr(lgp_pkg::OFF_CMD, 32'h1);
    xerr(1'b0, lgp_pkg::OFF_ADDR);
    host.xfer(1'b0, lgp_pkg::OFF_STATUS, 32'h0, q, e);
    chk("busy", 32'h1, {31'h0, q[lgp_pkg::STATUS_RES_BIT]});
    idle();
    rd(lgp_pkg::OFF_ADDR, 32'h0);
    rd(lgp_pkg::OFF_LINES, 32'h0040_0700);
    rd(lgp_pkg::OFF_POWER, 32'h0032_2007);
    rd(lgp_pkg::OFF_DISP, 32'h0000_00ff);
    rd(lgp_pkg::OFF_GRAYCFG, 32'h0);
    rd(lgp_pkg::OFF_PALETTE + 8'h08, 32'h0);
    $display("test command reset done");
    // pin reset refuses writes, then restores hardware defaults
    host.pin(1'b0);
    repeat (8) @(posedge pclk);
    xerr(1'b1, lgp_pkg::OFF_POWER);
    host.pin(1'b1);
    idle();
    hw_defaults();
    $display("test pin reset done");
    wrap_up();
  end
  // watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    wrap_up();
  end
endmodule
